// >>> core/ipv6_multicast_forward_qos.sv
// Operation
// - Replicate to LAN port when host joined
// - No replication where no host joined, except site scope
// - Never send back out ingress port
// - Listener messages stay on their interface
// - Link-scoped traffic stays on its interface
// - Site scope to other LAN ports only
// - Other LAN multicast goes to upstream
// - Source filtering applied per interface
// - Version-1 report sets per-group compat mode
// - Exclude-none plus exclude-source gives exclude-none
// - Query answer: one record per merged entry
// - Prioritisation optional, enabled by input
// - Downstream queue priority from traffic class byte only
// - Two downstream queues per LAN port
// - Map table or top bit picks queue
// - No upstream queues
// - Upstream class byte kept or zeroed
// - Upstream tag priority from top three bits
// - Upstream priority by ingress LAN port
// - Merge drops timed exclude sources and timers
`timescale 1ns/1ns
`default_nettype none
module ipv6_multicast_forward_qos
   import mcast_fwd_pkg::*;
#(
   parameter int NLAN = 2,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire pkt_desc_t in_desc,
   output logic out_valid,
   input wire logic out_ready,
   output logic [NLAN:0] out_egress,
   output logic out_queue_hi,
   output logic [TC_W-1:0] out_tclass,
   output logic [PCP_W-1:0] out_pcp,
   output logic out_up_hi,
   output logic [HANDLE_W-1:0] out_handle,
   input wire logic upd_valid,
   input wire logic [PORT_W-1:0] upd_port,
   input wire logic [GRP_W-1:0] upd_grp,
   input wire logic upd_leave,
   input wire logic upd_v1,
   input wire logic upd_excl,
   input wire logic upd_src_ok,
   input wire logic [SRC_W-1:0] upd_src,
   input wire logic upd_src_tmr_nz,
   input wire logic qos_en,
   input wire logic map_en,
   input wire logic [7:0] prio_map,
   input wire logic clear_tc,
   input wire logic [NLAN-1:0] port_hi,
   input wire logic gq_start,
   output logic gq_busy,
   output logic rec_valid,
   output logic [GRP_W-1:0] rec_grp,
   output logic rec_excl,
   output logic rec_src_ok,
   output logic [SRC_W-1:0] rec_src,
   output logic gq_done
);
   localparam int NGRP = 1 << GRP_W;
   localparam logic [GRP_W-1:0] LAST_GRP = GRP_W'(NGRP - 1);

   typedef struct packed {
      logic [NLAN-1:0][NGRP-1:0][$bits(mbr_t)-1:0] tbl;
      logic out_valid;
      logic [NLAN:0] egress;
      logic q_hi;
      logic [TC_W-1:0] tclass;
      logic [PCP_W-1:0] pcp;
      logic up_hi;
      logic [HANDLE_W-1:0] handle;
      walk_t walk;
      logic [GRP_W-1:0] wg;
      logic rec_valid;
      logic [GRP_W-1:0] rec_grp;
      logic rec_excl;
      logic rec_src_ok;
      logic [SRC_W-1:0] rec_src;
      logic gq_done;
   } st_t;

   st_t s_r;
   st_t s_nxt;

   // ==========================================================
   // Input buffer
   stream_if #(.W(DESC_W)) fin ();
   stream_if #(.W(DESC_W)) fout ();
   assign fin.valid = in_valid;
   assign fin.data = in_desc;
   assign in_ready = fin.ready;

   sync_fifo #(.W(DESC_W), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .wr(fin.snk),
      .rd(fout.src)
   );

   // ==========================================================
   // Merge of one group across LAN ports
   function automatic mrec_t merge_grp(input st_t st,
                                       input logic [GRP_W-1:0] g);
      mrec_t m;
      mbr_t r;
      logic any_ex;
      logic ex_same;
      logic xs_set;
      logic [SRC_W-1:0] xs;
      logic is_set;
      logic is_multi;
      logic [SRC_W-1:0] is_src;
      logic inc_hit;
      m = '0;
      any_ex = 1'b0;
      ex_same = 1'b1;
      xs_set = 1'b0;
      xs = '0;
      is_set = 1'b0;
      is_multi = 1'b0;
      is_src = '0;
      inc_hit = 1'b0;
      for (int p = 0; p < NLAN; p++)
      begin
         r = mbr_t'(st.tbl[p][g]);
         // Timed exclude sources are forwarded, so not blocked
         if (r.excl && r.src_tmr_nz)
            r.src_ok = 1'b0;
         if (r.valid && r.excl)
         begin
            any_ex = 1'b1;
            // Exclude-none on any port wins the intersection
            if (!r.src_ok)
               ex_same = 1'b0;
            else if (xs_set && xs != r.src)
               ex_same = 1'b0;
            else
            begin
               xs = r.src;
               xs_set = 1'b1;
            end
         end
         else if (r.valid)
         begin
            m.valid = 1'b1;
            if (is_set && is_src != r.src)
               is_multi = 1'b1;
            is_src = r.src;
            is_set = 1'b1;
         end
      end
      for (int p = 0; p < NLAN; p++)
      begin
         r = mbr_t'(st.tbl[p][g]);
         if (r.valid && !r.excl && r.src == xs)
            inc_hit = 1'b1;
      end
      if (any_ex)
      begin
         m.valid = 1'b1;
         m.excl = 1'b1;
         m.src_ok = ex_same && xs_set && !inc_hit;
         m.src = xs;
      end
      else if (is_multi)
      begin
         // One source slot: widen to exclude-none rather than lose traffic
         m.excl = 1'b1;
      end
      else
      begin
         m.src_ok = is_set;
         m.src = is_src;
      end
      return m;
   endfunction

   // ==========================================================
   // Forwarding decision on the buffer head
   pkt_desc_t d;
   logic from_up;
   logic scope_local;
   logic scope_site;
   logic up_fwd;
   logic [NLAN-1:0] lan_fwd;
   logic [NLAN:0] egress;
   logic [NLAN:0] port_hi_x;
   logic dn_hi;
   mrec_t wm;

   assign d = pkt_desc_t'(fout.data);
   assign from_up = d.ingress == UPSTREAM_PORT;
   assign scope_local = d.mld || d.scope <= SCOPE_LINK;
   assign scope_site = d.scope == SCOPE_SITE;
   assign up_fwd = !scope_local && !scope_site && !from_up;

   genvar gp;
   generate
      for (gp = 0; gp < NLAN; gp++)
      begin : g_lan
         mbr_t r;
         logic hit;
         logic sub;
         assign r = mbr_t'(s_r.tbl[gp][d.grp]);
         assign hit = r.src_ok && r.src == d.src;
         // Each port filters on its own record only
         assign sub = r.valid &&
                      (r.excl ? !(hit && !r.src_tmr_nz) : hit);
         assign lan_fwd[gp] = !scope_local &&
                              d.ingress != PORT_W'(gp + 1) &&
                              (scope_site ? !from_up : sub);
      end
   endgenerate

   assign egress = {lan_fwd, up_fwd};
   assign port_hi_x = {port_hi, 1'b0};
   assign dn_hi = map_en ? prio_map[d.tclass[TC_TOP:TC_PCP_LO]]
                         : d.tclass[TC_TOP];
   assign fout.ready = !s_r.out_valid || out_ready;
   assign wm = merge_grp(s_r, s_r.wg);

   // ==========================================================
   // Next state
   always_comb
   begin
      mbr_t u;
      mbr_t old;
      logic [PORT_W-1:0] ui;
      s_nxt = s_r;
      u = '0;
      old = '0;
      ui = upd_port - 1'b1;
      // Membership updates from the listener engines
      if (upd_valid && upd_port != UPSTREAM_PORT &&
          upd_port <= PORT_W'(NLAN))
      begin
         old = mbr_t'(s_r.tbl[ui][upd_grp]);
         u = old;
         if (upd_leave || (!upd_excl && !upd_src_ok && !upd_v1))
            u = '0;
         else if (upd_v1)
         begin
            u = '0;
            u.valid = 1'b1;
            u.v1 = 1'b1;
            u.excl = 1'b1;
         end
         else if (!old.v1)
         begin
            u.valid = 1'b1;
            u.excl = upd_excl;
            u.src_ok = upd_src_ok;
            u.src = upd_src;
            u.src_tmr_nz = upd_src_tmr_nz;
         end
         s_nxt.tbl[ui][upd_grp] = u;
      end
      // Output stage
      if (out_ready)
         s_nxt.out_valid = 1'b0;
      if (fout.valid && fout.ready)
      begin
         // Packets with no egress are dropped here
         s_nxt.out_valid = egress != '0;
         s_nxt.egress = egress;
         s_nxt.handle = d.handle;
         s_nxt.tclass = d.tclass;
         s_nxt.q_hi = 1'b0;
         s_nxt.pcp = '0;
         s_nxt.up_hi = 1'b0;
         if (qos_en)
         begin
            // Any copy towards hosts is queued by class, whatever its ingress
            if (lan_fwd != '0)
               s_nxt.q_hi = dn_hi;
            // Upstream gets no queue, only markings; one class byte is
            // shared by all copies, so a cleared byte reaches LAN copies too
            if (up_fwd)
            begin
               if (clear_tc)
                  s_nxt.tclass = '0;
               s_nxt.pcp = d.tclass[TC_TOP:TC_PCP_LO];
               s_nxt.up_hi = port_hi_x[d.ingress];
            end
         end
      end
      // General query walk
      s_nxt.rec_valid = 1'b0;
      s_nxt.gq_done = 1'b0;
      case (s_r.walk)
         WALK_IDLE:
         begin
            s_nxt.wg = '0;
            if (gq_start)
               s_nxt.walk = WALK_SCAN;
         end
         WALK_SCAN:
         begin
            s_nxt.rec_valid = wm.valid;
            s_nxt.rec_grp = s_r.wg;
            s_nxt.rec_excl = wm.excl;
            s_nxt.rec_src_ok = wm.src_ok;
            s_nxt.rec_src = wm.src;
            if (s_r.wg == LAST_GRP)
               s_nxt.walk = WALK_DONE;
            else
               s_nxt.wg = s_r.wg + 1'b1;
         end
         WALK_DONE:
         begin
            s_nxt.gq_done = 1'b1;
            s_nxt.walk = WALK_IDLE;
         end
         default:
            s_nxt.walk = WALK_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // ==========================================================
   // Outputs
   assign out_valid = s_r.out_valid;
   assign out_egress = s_r.egress;
   assign out_queue_hi = s_r.q_hi;
   assign out_tclass = s_r.tclass;
   assign out_pcp = s_r.pcp;
   assign out_up_hi = s_r.up_hi;
   assign out_handle = s_r.handle;
   assign gq_busy = s_r.walk != WALK_IDLE;
   assign rec_valid = s_r.rec_valid;
   assign rec_grp = s_r.rec_grp;
   assign rec_excl = s_r.rec_excl;
   assign rec_src_ok = s_r.rec_src_ok;
   assign rec_src = s_r.rec_src;
   assign gq_done = s_r.gq_done;
endmodule // ipv6_multicast_forward_qos
`default_nettype wire

// >>> core/mcast_fwd_pkg.sv
`default_nettype none
package mcast_fwd_pkg;
   // ==========================================================
   // Widths
   localparam int PORT_W = 2;
   localparam int GRP_W = 4;
   localparam int SRC_W = 8;
   localparam int HANDLE_W = 16;
   localparam int TC_W = 8;
   localparam int PCP_W = 3;
   localparam int FIFO_DEPTH = 16;
   // ==========================================================
   // Codes
   localparam logic [PORT_W-1:0] UPSTREAM_PORT = 2'h0;
   localparam logic [3:0] SCOPE_LINK = 4'h2;
   localparam logic [3:0] SCOPE_SITE = 4'h5;
   localparam int TC_TOP = 7;
   localparam int TC_PCP_LO = 5;
   // ==========================================================
   // Types
   typedef struct packed {
      logic [PORT_W-1:0] ingress;
      logic mld;
      logic [3:0] scope;
      logic [GRP_W-1:0] grp;
      logic [SRC_W-1:0] src;
      logic [TC_W-1:0] tclass;
      logic [HANDLE_W-1:0] handle;
   } pkt_desc_t;
   localparam int DESC_W = $bits(pkt_desc_t);
   typedef struct packed {
      logic valid;
      logic v1;
      logic excl;
      logic src_ok;
      logic [SRC_W-1:0] src;
      logic src_tmr_nz;
   } mbr_t;
   typedef struct packed {
      logic valid;
      logic excl;
      logic src_ok;
      logic [SRC_W-1:0] src;
   } mrec_t;
   typedef enum logic [1:0] {WALK_IDLE, WALK_SCAN, WALK_DONE} walk_t;
endpackage
`default_nettype wire

// >>> core/stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int W = 8) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface // stream_if
`default_nettype wire

// >>> core/sync_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sync_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rstn,
   stream_if.snk wr,
   stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fst_t;
   fst_t s_r;
   fst_t s_nxt;
   logic push;
   logic pop;
   assign wr.ready = s_r.cnt != FULL_CNT;
   assign rd.valid = s_r.cnt != '0;
   assign rd.data = s_r.mem[s_r.rp];
   assign push = wr.valid && wr.ready;
   assign pop = rd.valid && rd.ready;
   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wp] = wr.data;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (pop)
         s_nxt.rp = s_r.rp + 1'b1;
      // Simultaneous push and pop leaves the count alone
      if (push && !pop)
         s_nxt.cnt = s_r.cnt + 1'b1;
      else if (pop && !push)
         s_nxt.cnt = s_r.cnt - 1'b1;
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule // sync_fifo
`default_nettype wire

// >>> tb/mcast_fwd_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mcast_fwd_checker
   import mcast_fwd_pkg::*;
#(
   parameter int NLAN = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire logic [NLAN:0] out_egress,
   input wire logic out_queue_hi,
   input wire logic [TC_W-1:0] out_tclass,
   input wire logic [PCP_W-1:0] out_pcp,
   input wire logic out_up_hi,
   input wire logic [HANDLE_W-1:0] out_handle,
   input wire logic qos_en,
   input wire logic map_en,
   input wire logic [7:0] prio_map,
   input wire logic clear_tc,
   input wire logic gq_start,
   input wire logic gq_busy,
   input wire logic rec_valid,
   input wire logic gq_done
);
   // ==========================================================
   // Decision stream and query walk
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence stall_s;
      out_valid && !out_ready;
   endsequence
   sequence walk_s;
      gq_start && !gq_busy;
   endsequence
   hold_out_a:
      assert property (stall_s |=> out_valid && $stable(out_handle)
         && $stable(out_egress)) else $error("decision changed in stall");
   no_empty_a:
      assert property (out_valid |-> out_egress != '0)
         else $error("decision without egress");
   qos_off_a:
      assert property (out_valid && !qos_en |-> !out_queue_hi && !out_up_hi
         && out_pcp == '0) else $error("priority set with qos off");
   top_bit_a:
      assert property (out_valid && qos_en && !out_egress[0] && !map_en
         |-> out_queue_hi == out_tclass[TC_TOP]) else $error("queue wrong");
   map_pick_a:
      assert property (out_valid && qos_en && !out_egress[0] && map_en |->
         out_queue_hi == prio_map[out_tclass[TC_TOP:TC_PCP_LO]])
         else $error("queue not from map");
   pcp_copy_a:
      assert property (out_valid && qos_en && out_egress[0] && !clear_tc |->
         out_pcp == out_tclass[TC_TOP:TC_PCP_LO]) else $error("pcp wrong");
   clear_up_a:
      assert property (out_valid && qos_en && out_egress[0] && clear_tc |->
         out_tclass == '0) else $error("upstream class not cleared");
   walk_len_a:
      assert property (walk_s |=> (gq_busy && !gq_done) [*8] ##10 gq_done)
         else $error("query walk length wrong");
   done_once_a:
      assert property (gq_done |=> !gq_done && !gq_busy && !rec_valid)
         else $error("walk end not single");
   rec_in_walk_a:
      assert property (rec_valid |-> gq_busy && !gq_done)
         else $error("record outside walk");
endmodule // mcast_fwd_checker
`default_nettype wire

// >>> tb/lan_sink_model.sv
`timescale 1ns/1ns
`default_nettype none
module lan_sink_model
   import mcast_fwd_pkg::*;
#(
   parameter int NLAN = 2
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [1:0] mode,
   input wire logic out_valid,
   output var logic out_ready,
   input wire logic [NLAN:0] out_egress,
   input wire logic out_queue_hi,
   input wire logic [TC_W-1:0] out_tclass,
   input wire logic [PCP_W-1:0] out_pcp,
   input wire logic out_up_hi,
   input wire logic [HANDLE_W-1:0] out_handle
);
   // ==========================================================
   // Consumer pacing and decision log
   logic tog;
   int cnt;
   logic [HANDLE_W-1:0] lh [64];
   logic [NLAN:0] leg [64];
   logic [TC_W-1:0] ltc [64];
   logic [PCP_W-1:0] lp [64];
   logic lq [64];
   logic lu [64];
   initial
   begin
      tog = 1'h0;
      cnt = 0;
      out_ready = 1'h0;
   end
   // Mode 0 takes at once, 1 stalls, 2 takes every other cycle
   always @(negedge clk)
   begin
      tog <= !tog;
      out_ready <= (mode == 2'h0) || (mode == 2'h2 && tog);
   end
   always @(posedge clk)
   begin
      if (rstn && out_valid && out_ready && cnt < 64)
      begin
         lh[cnt] = out_handle;
         leg[cnt] = out_egress;
         ltc[cnt] = out_tclass;
         lp[cnt] = out_pcp;
         lq[cnt] = out_queue_hi;
         lu[cnt] = out_up_hi;
         cnt = cnt + 1;
      end
   end
endmodule // lan_sink_model
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import mcast_fwd_pkg::*;
   typedef struct packed {
      logic [15:0] h;
      logic [2:0] eg;
      logic [1:0] ing;
      logic [7:0] tc;
   } exp_t;
   logic clk, rstn, in_valid, in_ready, out_valid, out_ready, out_queue_hi;
   logic out_up_hi, upd_valid, upd_leave, upd_v1, upd_excl, upd_src_ok;
   logic upd_src_tmr_nz, qos_en, map_en, clear_tc, gq_start, gq_busy;
   logic rec_valid, rec_excl, rec_src_ok, gq_done;
   pkt_desc_t in_desc;
   logic [2:0] out_egress, out_pcp;
   logic [7:0] out_tclass, prio_map, upd_src, rec_src;
   logic [15:0] out_handle, hnd;
   logic [1:0] upd_port, port_hi, mode;
   logic [3:0] upd_grp, rec_grp;
   int error_cnt, n_tests, ei, n_done, k, acc;
   exp_t eq[$];
   logic [13:0] rq[$];
   ipv6_multicast_forward_qos #(.NLAN(2), .DEPTH(16)) dut (.clk, .rstn,
      .in_valid, .in_ready, .in_desc, .out_valid, .out_ready, .out_egress,
      .out_queue_hi, .out_tclass, .out_pcp, .out_up_hi, .out_handle,
      .upd_valid, .upd_port, .upd_grp, .upd_leave, .upd_v1, .upd_excl,
      .upd_src_ok, .upd_src, .upd_src_tmr_nz, .qos_en, .map_en, .prio_map,
      .clear_tc, .port_hi, .gq_start, .gq_busy, .rec_valid, .rec_grp,
      .rec_excl, .rec_src_ok, .rec_src, .gq_done);
   lan_sink_model #(.NLAN(2)) p (.clk, .rstn, .mode, .out_valid, .out_ready,
      .out_egress, .out_queue_hi, .out_tclass, .out_pcp, .out_up_hi,
      .out_handle);
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic finish_test;
      $display("Checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Flags: leave, v1, excl, src_ok, timer
   task automatic upd(input logic [1:0] pt, input logic [3:0] g,
                      input logic [4:0] f, input logic [7:0] s);
      @(negedge clk);
      {upd_port, upd_grp, upd_src} = {pt, g, s};
      {upd_leave, upd_v1, upd_excl, upd_src_ok, upd_src_tmr_nz} = f;
      upd_valid = 1'h1;
      @(negedge clk);
      upd_valid = 1'h0;
   endtask
   // Valid stays up so sends run back to back; drain drops it
   task automatic send(input logic [1:0] ing, input logic [4:0] ms,
      input logic [3:0] g, input logic [7:0] s, input logic [7:0] tc,
      input logic [2:0] eg);
      @(negedge clk);
      in_valid = 1'h1;
      in_desc = '{ing, ms[4], ms[3:0], g, s, tc, hnd};
      if (eg != 3'h0)
         eq.push_back('{hnd, eg, ing, tc});
      hnd++;
      while (!in_ready)
         @(negedge clk);
   endtask
   task automatic drain;
      exp_t e;
      @(negedge clk);
      in_valid = 1'h0;
      k = 0;
      while (p.cnt < eq.size() && k < 500)
      begin
         @(negedge clk);
         k++;
      end
      repeat (6) @(negedge clk);
      chk("count", eq.size(), p.cnt);
      for (; ei < eq.size(); ei++)
      begin
         e = eq[ei];
         chk("handle", e.h, p.lh[ei]);
         chk("egress", e.eg, p.leg[ei]);
         chk("tclass", (qos_en && clear_tc && e.eg[0]) ? 8'h00 : e.tc,
             p.ltc[ei]);
         if (e.eg[2:1] != 2'h0)
            chk("queue_hi", qos_en && (map_en ? prio_map[e.tc[7:5]] :
                e.tc[7]), p.lq[ei]);
         if (e.eg[0])
         begin
            chk("pcp", qos_en ? e.tc[7:5] : 3'h0, p.lp[ei]);
            chk("up_hi", qos_en && port_hi[e.ing - 2'h1], p.lu[ei]);
         end
      end
   endtask
   // ==========================================================
   // Clock, monitors, watchdog
   initial
   begin
      clk = 1'h0;
      forever #5 clk = !clk;
   end
   always @(posedge clk)
      if (rstn && rec_valid)
         rq.push_back({rec_grp, rec_excl, rec_src_ok,
                       rec_src_ok ? rec_src : 8'h00});
   always @(posedge clk)
      if (rstn && gq_done)
         n_done++;
   initial
   begin
      #50000;
      error_cnt++;
      $display("Error watchdog expected end seen timeout");
      finish_test;
   end
   // ==========================================================
   // Tests
   initial
   begin
      {rstn, in_valid, upd_valid, qos_en, map_en, clear_tc, gq_start} = '0;
      {prio_map, port_hi, mode, hnd, in_desc} = '0;
      {upd_port, upd_grp, upd_src, upd_leave, upd_v1} = '0;
      {upd_excl, upd_src_ok, upd_src_tmr_nz} = '0;
      {error_cnt, n_tests, ei, n_done, acc} = '0;
      repeat (5) @(negedge clk);
      rstn = 1'h1;
      chk("in_ready", 1'h1, in_ready);
      chk("out_valid", 1'h0, out_valid);
      upd(2'h1, 4'h1, 5'h08, 8'h00);
      upd(2'h1, 4'h2, 5'h04, 8'h00);
      upd(2'h2, 4'h2, 5'h06, 8'h20);
      upd(2'h2, 4'h4, 5'h07, 8'h30);
      upd(2'h1, 4'h6, 5'h02, 8'h40);
      upd(2'h3, 4'h7, 5'h04, 8'h00);
      gq_start = 1'h1;
      @(negedge clk);
      gq_start = 1'h0;
      repeat (3) @(negedge clk);
      gq_start = 1'h1;
      @(negedge clk);
      gq_start = 1'h0;
      repeat (20) @(negedge clk);
      chk("walks", 1'h1, n_done);
      chk("gq_busy", 1'h0, gq_busy);
      chk("records", 16'h4, rq.size());
      chk("rec_g1", 14'h0600, rq[0]);
      chk("rec_g2", 14'h0a00, rq[1]);
      chk("rec_g4", 14'h1200, rq[2]);
      chk("rec_g6", 14'h1940, rq[3]);
      $display("Query walk test done");
      mode = 2'h2;
      send(2'h0, 5'h0e, 4'h1, 8'h10, 8'h11, 3'h2);
      send(2'h0, 5'h0e, 4'h2, 8'h10, 8'h22, 3'h6);
      send(2'h0, 5'h0e, 4'h2, 8'h20, 8'h33, 3'h2);
      send(2'h0, 5'h0e, 4'h3, 8'h10, 8'h00, 3'h0);
      send(2'h0, 5'h0e, 4'h7, 8'h10, 8'h00, 3'h0);
      send(2'h1, 5'h0e, 4'h2, 8'h10, 8'h44, 3'h5);
      send(2'h1, 5'h05, 4'h9, 8'h10, 8'h55, 3'h4);
      send(2'h0, 5'h05, 4'h9, 8'h10, 8'h00, 3'h0);
      send(2'h1, 5'h02, 4'h2, 8'h10, 8'h00, 3'h0);
      send(2'h1, 5'h1e, 4'h2, 8'h10, 8'h00, 3'h0);
      send(2'h0, 5'h0e, 4'h4, 8'h30, 8'h66, 3'h4);
      send(2'h0, 5'h0e, 4'h6, 8'h41, 8'h00, 3'h0);
      drain;
      upd(2'h1, 4'h1, 5'h06, 8'h10);
      send(2'h0, 5'h0e, 4'h1, 8'h10, 8'h00, 3'h2);
      drain;
      upd(2'h1, 4'h1, 5'h10, 8'h00);
      send(2'h0, 5'h0e, 4'h1, 8'h10, 8'h00, 3'h0);
      drain;
      $display("Forwarding test done");
      {qos_en, port_hi, mode} = {1'h1, 2'h2, 2'h0};
      send(2'h0, 5'h0e, 4'h2, 8'h10, 8'h80, 3'h6);
      send(2'h0, 5'h0e, 4'h2, 8'h10, 8'h7f, 3'h6);
      send(2'h2, 5'h0e, 4'h5, 8'h10, 8'ha5, 3'h1);
      send(2'h1, 5'h0e, 4'h5, 8'h10, 8'ha5, 3'h1);
      drain;
      {map_en, prio_map} = {1'h1, 8'h02};
      send(2'h0, 5'h0e, 4'h2, 8'h10, 8'h20, 3'h6);
      send(2'h0, 5'h0e, 4'h2, 8'h10, 8'h80, 3'h6);
      drain;
      clear_tc = 1'h1;
      send(2'h2, 5'h0e, 4'h5, 8'h10, 8'ha5, 3'h1);
      send(2'h1, 5'h05, 4'h9, 8'h10, 8'h20, 3'h4);
      send(2'h1, 5'h0e, 4'h2, 8'h10, 8'h20, 3'h5);
      drain;
      qos_en = 1'h0;
      send(2'h2, 5'h0e, 4'h5, 8'h10, 8'ha5, 3'h1);
      drain;
      $display("Priority test done");
      mode = 2'h1;
      repeat (24)
      begin
         @(negedge clk);
         in_valid = 1'h1;
         in_desc = '{2'h0, 1'h0, 4'he, 4'h2, 8'h10, 8'h00, hnd};
         if (in_ready)
         begin
            eq.push_back('{hnd, 3'h6, 2'h0, 8'h00});
            hnd++;
            acc++;
         end
      end
      chk("in_ready_full", 1'h0, in_ready);
      chk("accepts", 1'h1, acc >= 16 && acc <= 17);
      mode = 2'h2;
      drain;
      chk("in_ready_empty", 1'h1, in_ready);
      $display("Buffer test done");
      finish_test;
   end
endmodule // tb_top
bind ipv6_multicast_forward_qos mcast_fwd_checker #(.NLAN(NLAN)) chk_i (
   .clk, .rstn, .out_valid, .out_ready, .out_egress, .out_queue_hi,
   .out_tclass, .out_pcp, .out_up_hi, .out_handle, .qos_en, .map_en,
   .prio_map, .clear_tc, .gq_start, .gq_busy, .rec_valid, .gq_done);
`default_nettype wire
